// ==== rtl/sbpt_pkg.sv ====
// Constants and types shared by the single-bunch phase tracker
package sbpt_pkg;
	localparam int DATA_W = 32;
	localparam int SMP_W = 16;
	localparam int MIX_W = 18;
	localparam int PH_W = 16;
	localparam int ADDR_W = 8;
	localparam int BN_W = 10;
	localparam int DEC_W = 12;
	localparam int SH_W = 5;
	localparam int IT_W = 4;
	localparam int FIFO_DEPTH = 4;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_BUNCH = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_GAIN = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SETPT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_RANGE = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_DECIM = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MAG = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PHASE = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_ERROR = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_SHIFT = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_TRACK = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_UPD = 8'h2C;
	// Control register fields
	localparam int CTRL_LOOP = 0;
	localparam int CTRL_FOLLOW = 1;
	localparam int CTRL_GATE = 2;
	// Reset values
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [BN_W-1:0] BUNCH_RST = 10'h001;
	localparam logic [PH_W-1:0] GAIN_RST = 16'h0000;
	localparam logic [PH_W-1:0] SETPT_RST = 16'h0000;
	localparam logic [DATA_W-1:0] RANGE_RST = 32'h0000_0000;
	localparam logic [DEC_W-1:0] DECIM_RST = 12'h064;
	// Datapath constants
	localparam logic [SH_W-1:0] SHIFT_MAX = 5'h1E;
	localparam logic signed [DATA_W-1:0] HALF_FS = 32'sh4000_0000;
	localparam logic [PH_W-1:0] PH_HALF = 16'h8000;
	localparam logic [IT_W-1:0] ITER_LAST = 4'hF;
	localparam int MIX_LSB = 14;
	localparam int CORD_PRE = 2;

	typedef struct packed {
		logic signed [MIX_W-1:0] i;
		logic signed [MIX_W-1:0] q;
	} sbpt_iq_t;

	typedef enum logic [1:0] {
		ST_ACC = 2'b00,
		ST_NORM = 2'b01,
		ST_CORD = 2'b10,
		ST_LOOP = 2'b11
	} sbpt_state_t;
endpackage

// ==== rtl/sbpt_top.sv ====
// Single-bunch phase tracker: mixer, FIFO, CIC, normalizer, CORDIC and frequency loop
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sbpt_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic [AW:0] cnt_next;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = cnt_reg != '0;
	assign out_data = mem_reg[rp_reg];
	assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wp_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
			end
			cnt_reg <= cnt_next;
			// Registered ready keeps the top output flop-driven
			in_ready <= cnt_next < (AW+1)'(DEPTH);
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sbpt_top #(
	parameter int FIFO_DEPTH = sbpt_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Bunch sample stream
	input wire logic S_VALID,
	input wire logic signed [sbpt_pkg::SMP_W-1:0] S_SAMPLE,
	input wire logic [sbpt_pkg::BN_W-1:0] S_BUNCH,
	output logic S_READY,
	// Drive generator
	input wire logic signed [sbpt_pkg::SMP_W-1:0] DRV0_COS,
	input wire logic signed [sbpt_pkg::SMP_W-1:0] DRV0_SIN,
	input wire logic [sbpt_pkg::DATA_W-1:0] DRV0_FREQ,
	input wire logic SET_SEL_LSB,
	output logic [sbpt_pkg::DATA_W-1:0] TRACK_FREQ,
	output logic [sbpt_pkg::DATA_W-1:0] DRV2_CORR,
	output logic [sbpt_pkg::BN_W-1:0] SB_BUNCH,
	// Register port
	input wire logic [sbpt_pkg::ADDR_W-1:0] BUS_ADDR,
	input wire logic [sbpt_pkg::DATA_W-1:0] BUS_WDATA,
	input wire logic BUS_WR,
	input wire logic BUS_RD,
	output logic [sbpt_pkg::DATA_W-1:0] BUS_RDATA
);
	localparam int W = sbpt_pkg::DATA_W;

	function automatic logic above_half(input logic signed [W-1:0] v);
		above_half = v[W-1] ? (v < -sbpt_pkg::HALF_FS) : (v > sbpt_pkg::HALF_FS);
	endfunction

	function automatic logic [sbpt_pkg::PH_W-1:0] atan_step(input logic [sbpt_pkg::IT_W-1:0] i);
		case (i)
			4'h0: atan_step = 16'h2000;
			4'h1: atan_step = 16'h12E4;
			4'h2: atan_step = 16'h09FB;
			4'h3: atan_step = 16'h0511;
			4'h4: atan_step = 16'h028B;
			4'h5: atan_step = 16'h0146;
			4'h6: atan_step = 16'h00A3;
			4'h7: atan_step = 16'h0051;
			4'h8: atan_step = 16'h0029;
			4'h9: atan_step = 16'h0014;
			4'hA: atan_step = 16'h000A;
			4'hB: atan_step = 16'h0005;
			4'hC: atan_step = 16'h0003;
			4'hD: atan_step = 16'h0001;
			4'hE: atan_step = 16'h0001;
			default: atan_step = 16'h0000;
		endcase
	endfunction

	logic rst_meta_reg;
	logic rst_n;
	logic [2:0] ctrl_reg;
	logic [sbpt_pkg::BN_W-1:0] bunch_reg;
	logic signed [sbpt_pkg::PH_W-1:0] gain_reg;
	logic [sbpt_pkg::PH_W-1:0] setpt_reg;
	logic [W-1:0] range_reg;
	logic [sbpt_pkg::DEC_W-1:0] decim_reg;
	logic [W-1:0] mag_reg;
	logic [sbpt_pkg::PH_W-1:0] phase_reg;
	logic [sbpt_pkg::PH_W-1:0] error_reg;
	logic [sbpt_pkg::SH_W-1:0] shift_reg;
	logic [W-1:0] track_snap_reg;
	logic [W-1:0] upd_reg;
	sbpt_pkg::sbpt_state_t state_reg;
	logic signed [W-1:0] acc_i_reg;
	logic signed [W-1:0] acc_q_reg;
	logic [sbpt_pkg::DEC_W-1:0] turn_reg;
	logic signed [W-1:0] x_reg;
	logic signed [W-1:0] y_reg;
	logic [sbpt_pkg::PH_W-1:0] ang_reg;
	logic [sbpt_pkg::SH_W-1:0] sh_reg;
	logic [sbpt_pkg::IT_W-1:0] it_reg;
	logic signed [W-1:0] integ_reg;
	logic signed [2*sbpt_pkg::SMP_W-1:0] prod_i;
	logic signed [2*sbpt_pkg::SMP_W-1:0] prod_q;
	sbpt_pkg::sbpt_iq_t mix;
	sbpt_pkg::sbpt_iq_t fifo_out;
	logic fifo_valid;
	logic fifo_pop;
	logic match;
	logic closed;
	logic [sbpt_pkg::PH_W-1:0] err;
	logic signed [W:0] integ_sum;
	logic signed [W:0] range_s;
	logic signed [W-1:0] integ_next;
	logic [sbpt_pkg::DEC_W-1:0] decim_last;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register port
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= sbpt_pkg::CTRL_RST;
			bunch_reg <= sbpt_pkg::BUNCH_RST;
			gain_reg <= sbpt_pkg::GAIN_RST;
			setpt_reg <= sbpt_pkg::SETPT_RST;
			range_reg <= sbpt_pkg::RANGE_RST;
			decim_reg <= sbpt_pkg::DECIM_RST;
		end else if (BUS_WR) begin
			if (BUS_ADDR == sbpt_pkg::OFS_CTRL) begin
				ctrl_reg <= BUS_WDATA[2:0];
			end else if (BUS_ADDR == sbpt_pkg::OFS_BUNCH) begin
				bunch_reg <= BUS_WDATA[sbpt_pkg::BN_W-1:0];
			end else if (BUS_ADDR == sbpt_pkg::OFS_GAIN) begin
				gain_reg <= BUS_WDATA[sbpt_pkg::PH_W-1:0];
			end else if (BUS_ADDR == sbpt_pkg::OFS_SETPT) begin
				setpt_reg <= BUS_WDATA[sbpt_pkg::PH_W-1:0];
			end else if (BUS_ADDR == sbpt_pkg::OFS_RANGE) begin
				range_reg <= {1'b0, BUS_WDATA[W-2:0]};
			end else if (BUS_ADDR == sbpt_pkg::OFS_DECIM) begin
				decim_reg <= BUS_WDATA[sbpt_pkg::DEC_W-1:0];
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			BUS_RDATA <= '0;
		end else if (!BUS_RD) begin
			BUS_RDATA <= '0;
		end else if (BUS_ADDR == sbpt_pkg::OFS_CTRL) begin
			BUS_RDATA <= W'(ctrl_reg);
		end else if (BUS_ADDR == sbpt_pkg::OFS_BUNCH) begin
			BUS_RDATA <= W'(bunch_reg);
		end else if (BUS_ADDR == sbpt_pkg::OFS_GAIN) begin
			BUS_RDATA <= W'(gain_reg);
		end else if (BUS_ADDR == sbpt_pkg::OFS_SETPT) begin
			BUS_RDATA <= W'(setpt_reg);
		end else if (BUS_ADDR == sbpt_pkg::OFS_RANGE) begin
			BUS_RDATA <= range_reg;
		end else if (BUS_ADDR == sbpt_pkg::OFS_DECIM) begin
			BUS_RDATA <= W'(decim_reg);
		end else if (BUS_ADDR == sbpt_pkg::OFS_MAG) begin
			BUS_RDATA <= mag_reg;
		end else if (BUS_ADDR == sbpt_pkg::OFS_PHASE) begin
			BUS_RDATA <= W'(phase_reg);
		end else if (BUS_ADDR == sbpt_pkg::OFS_ERROR) begin
			BUS_RDATA <= W'(error_reg);
		end else if (BUS_ADDR == sbpt_pkg::OFS_SHIFT) begin
			BUS_RDATA <= W'(shift_reg);
		end else if (BUS_ADDR == sbpt_pkg::OFS_TRACK) begin
			BUS_RDATA <= track_snap_reg;
		end else if (BUS_ADDR == sbpt_pkg::OFS_UPD) begin
			BUS_RDATA <= upd_reg;
		end else begin
			BUS_RDATA <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Down-conversion of the selected bunch into the FIFO
	assign match = S_BUNCH == bunch_reg;
	assign prod_i = S_SAMPLE * DRV0_COS;
	assign prod_q = S_SAMPLE * DRV0_SIN;
	assign mix.i = prod_i[2*sbpt_pkg::SMP_W-1:sbpt_pkg::MIX_LSB];
	assign mix.q = prod_q[2*sbpt_pkg::SMP_W-1:sbpt_pkg::MIX_LSB];
	// Pops only while integrating, so a long CORDIC pass backs up the stream
	assign fifo_pop = state_reg == sbpt_pkg::ST_ACC;
	assign decim_last = (decim_reg == '0) ? '0 : decim_reg - 1'b1;

	sbpt_fifo #(
		.WIDTH(2*sbpt_pkg::MIX_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(rst_n),
		.in_valid(S_VALID && match),
		.in_data(mix),
		.in_ready(S_READY),
		.out_valid(fifo_valid),
		.out_data(fifo_out),
		.out_ready(fifo_pop)
	);

	////////////////////////////////////////////////////////////////////////////
	// CIC, normalizer and CORDIC sequencer
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= sbpt_pkg::ST_ACC;
			acc_i_reg <= '0;
			acc_q_reg <= '0;
			turn_reg <= '0;
			x_reg <= '0;
			y_reg <= '0;
			ang_reg <= '0;
			sh_reg <= '0;
			it_reg <= '0;
		end else begin
			case (state_reg)
				sbpt_pkg::ST_ACC: begin
					if (fifo_valid) begin
						acc_i_reg <= acc_i_reg + W'(fifo_out.i);
						acc_q_reg <= acc_q_reg + W'(fifo_out.q);
						if (turn_reg >= decim_last) begin
							turn_reg <= '0;
							state_reg <= sbpt_pkg::ST_NORM;
							x_reg <= acc_i_reg + W'(fifo_out.i);
							y_reg <= acc_q_reg + W'(fifo_out.q);
							sh_reg <= '0;
						end else begin
							turn_reg <= turn_reg + 1'b1;
						end
					end
				end
				sbpt_pkg::ST_NORM: begin
					acc_i_reg <= '0;
					acc_q_reg <= '0;
					if (above_half(x_reg) || above_half(y_reg) || sh_reg == sbpt_pkg::SHIFT_MAX) begin
						state_reg <= sbpt_pkg::ST_CORD;
						it_reg <= '0;
						// Headroom for the CORDIC gain; left half plane is folded over
						x_reg <= x_reg[W-1] ? -(x_reg >>> sbpt_pkg::CORD_PRE)
							: (x_reg >>> sbpt_pkg::CORD_PRE);
						y_reg <= x_reg[W-1] ? -(y_reg >>> sbpt_pkg::CORD_PRE)
							: (y_reg >>> sbpt_pkg::CORD_PRE);
						ang_reg <= x_reg[W-1] ? sbpt_pkg::PH_HALF : '0;
					end else begin
						x_reg <= x_reg <<< 1;
						y_reg <= y_reg <<< 1;
						sh_reg <= sh_reg + 1'b1;
					end
				end
				sbpt_pkg::ST_CORD: begin
					if (y_reg[W-1]) begin
						x_reg <= x_reg - (y_reg >>> it_reg);
						y_reg <= y_reg + (x_reg >>> it_reg);
						ang_reg <= ang_reg - atan_step(it_reg);
					end else begin
						x_reg <= x_reg + (y_reg >>> it_reg);
						y_reg <= y_reg - (x_reg >>> it_reg);
						ang_reg <= ang_reg + atan_step(it_reg);
					end
					it_reg <= it_reg + 1'b1;
					if (it_reg == sbpt_pkg::ITER_LAST) begin
						state_reg <= sbpt_pkg::ST_LOOP;
					end
				end
				default: begin
					state_reg <= sbpt_pkg::ST_ACC;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Phase loop
	assign closed = ctrl_reg[sbpt_pkg::CTRL_LOOP]
		&& (!ctrl_reg[sbpt_pkg::CTRL_GATE] || SET_SEL_LSB);
	assign err = setpt_reg - ang_reg;
	assign integ_sum = {integ_reg[W-1], integ_reg}
		+ (W+1)'(gain_reg * $signed(err));
	assign range_s = $signed({1'b0, range_reg});
	always_comb begin
		if (integ_sum > range_s) begin
			integ_next = W'(range_s);
		end else if (integ_sum < -range_s) begin
			integ_next = W'(-range_s);
		end else begin
			integ_next = W'(integ_sum);
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			integ_reg <= '0;
		end else if (!closed) begin
			integ_reg <= '0;
		end else if (state_reg == sbpt_pkg::ST_LOOP) begin
			integ_reg <= integ_next;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			TRACK_FREQ <= '0;
			DRV2_CORR <= '0;
			SB_BUNCH <= sbpt_pkg::BUNCH_RST;
		end else begin
			TRACK_FREQ <= closed ? DRV0_FREQ + integ_reg : DRV0_FREQ;
			DRV2_CORR <= (closed && ctrl_reg[sbpt_pkg::CTRL_FOLLOW]) ? integ_reg : '0;
			SB_BUNCH <= bunch_reg;
		end
	end

	// Snapshot so software never mixes values from two updates
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			mag_reg <= '0;
			phase_reg <= '0;
			error_reg <= '0;
			shift_reg <= '0;
			track_snap_reg <= '0;
			upd_reg <= '0;
		end else if (state_reg == sbpt_pkg::ST_LOOP) begin
			mag_reg <= x_reg >>> sh_reg;
			phase_reg <= ang_reg;
			error_reg <= err;
			shift_reg <= sh_reg;
			track_snap_reg <= closed ? DRV0_FREQ + integ_next : DRV0_FREQ;
			upd_reg <= upd_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	open_hold_zero_a: assert property (!closed |=> integ_reg == '0 && DRV2_CORR == '0)
		else $error("integrator not held at zero while open");
	clamp_range_a: assert property (state_reg == sbpt_pkg::ST_LOOP && closed
		|=> integ_reg <= $signed({1'b0, $past(range_reg)})
		&& integ_reg >= -$signed({1'b0, $past(range_reg)}))
		else $error("correction outside range");
	track_open_a: assert property (!closed |=> TRACK_FREQ == $past(DRV0_FREQ))
		else $error("open loop frequency differs from drive 0");
	track_closed_a: assert property (closed |=> TRACK_FREQ == $past(DRV0_FREQ) + $past(integ_reg))
		else $error("closed loop frequency not corrected");
	drive2_follow_a: assert property (closed && ctrl_reg[sbpt_pkg::CTRL_FOLLOW]
		|=> DRV2_CORR == $past(integ_reg))
		else $error("drive 2 does not follow correction");
	gate_open_a: assert property (ctrl_reg[sbpt_pkg::CTRL_GATE] && !SET_SEL_LSB |-> !closed)
		else $error("loop closed with set select low");
	norm_stop_a: assert property (state_reg == sbpt_pkg::ST_NORM && !above_half(x_reg)
		&& !above_half(y_reg) && sh_reg != sbpt_pkg::SHIFT_MAX
		|=> x_reg == $past(x_reg) <<< 1 && sh_reg == $past(sh_reg) + 1'b1)
		else $error("normalizer stopped early");
	cordic_len_a: assert property ($rose(state_reg == sbpt_pkg::ST_CORD)
		|-> ##15 state_reg == sbpt_pkg::ST_CORD ##1 state_reg == sbpt_pkg::ST_LOOP)
		else $error("CORDIC pass length wrong");
	snap_error_a: assert property (state_reg == sbpt_pkg::ST_LOOP
		|=> error_reg == $past(setpt_reg) - phase_reg && shift_reg == $past(sh_reg))
		else $error("snapshot not consistent");
	decim_turns_a: assert property (state_reg == sbpt_pkg::ST_ACC && fifo_valid
		&& turn_reg < decim_last |=> state_reg == sbpt_pkg::ST_ACC)
		else $error("decimation ended early");

	closed_update_c: cover property (closed && state_reg == sbpt_pkg::ST_LOOP);
	clamp_hit_c: cover property (closed && state_reg == sbpt_pkg::ST_LOOP
		&& integ_sum > range_s);
	norm_shift_c: cover property (state_reg == sbpt_pkg::ST_LOOP && sh_reg != '0);
	fifo_full_c: cover property (S_VALID && match && !S_READY);
endmodule

`default_nettype wire

// ==== sim/sbpt_stream_model.sv ====
// Bunch sample stream and drive quadrature source facing the tracker
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sbpt_stream_model #(
	parameter int NB = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Scenario controls
	input wire logic burst,
	input wire logic [sbpt_pkg::BN_W-1:0] sel,
	input wire logic signed [sbpt_pkg::SMP_W-1:0] amp,
	input wire logic signed [sbpt_pkg::SMP_W-1:0] cos_v,
	input wire logic signed [sbpt_pkg::SMP_W-1:0] sin_v,
	// Stream toward the tracker
	output logic s_valid,
	output logic signed [sbpt_pkg::SMP_W-1:0] s_sample,
	output logic [sbpt_pkg::BN_W-1:0] s_bunch,
	output logic signed [sbpt_pkg::SMP_W-1:0] drv_cos,
	output logic signed [sbpt_pkg::SMP_W-1:0] drv_sin
);
	logic [sbpt_pkg::BN_W-1:0] slot_reg;

	// One sample per bunch slot; ready is not honoured, as a real ADC stream would not
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_reg <= 10'h001;
			s_valid <= 1'b0;
			s_bunch <= 10'h000;
			s_sample <= 16'sh0000;
			drv_cos <= 16'sh0000;
			drv_sin <= 16'sh0000;
		end else begin
			s_valid <= 1'b1;
			slot_reg <= (slot_reg == 10'(NB)) ? 10'h001 : slot_reg + 10'h001;
			s_bunch <= burst ? sel : slot_reg;
			// Other bunches carry the inverted signal, so taking one flips the phase
			s_sample <= (burst || slot_reg == sel) ? amp : -amp;
			drv_cos <= cos_v;
			drv_sin <= sin_v;
		end
	end
endmodule

`default_nettype wire

// ==== sim/sbpt_top_bench.sv ====
// Self-checking bench for the single-bunch phase tracker
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sbpt_top_bench;
	localparam logic [31:0] F = 32'h1234_5678;
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	logic BUS_WR = 1'b0;
	logic BUS_RD = 1'b0;
	logic [7:0] BUS_ADDR = 8'h00;
	logic [31:0] BUS_WDATA = 32'h0000_0000;
	logic [31:0] DRV0_FREQ = F;
	logic SET_SEL_LSB = 1'b0;
	logic burst = 1'b0;
	logic signed [15:0] cos_v = 16'sh4000;
	logic signed [15:0] sin_v = 16'sh0000;
	logic S_VALID, S_READY;
	logic signed [15:0] S_SAMPLE, DRV0_COS, DRV0_SIN;
	logic [9:0] S_BUNCH, SB_BUNCH;
	logic [31:0] TRACK_FREQ, DRV2_CORR, BUS_RDATA, d, u0;
	logic [15:0] dif;
	int err_count = 0;
	int n_tests = 0;
	int k;
	time t0;

	initial begin
		forever #10 CLK = ~CLK;
	end

	// Eight slots per turn keep a whole processing pass inside the FIFO, so no turn is lost
	sbpt_stream_model #(.NB(8)) far (.clk(CLK), .rst_n(RSTN), .burst(burst), .sel(10'h002),
		.amp(16'sh3000), .cos_v(cos_v), .sin_v(sin_v), .s_valid(S_VALID),
		.s_sample(S_SAMPLE), .s_bunch(S_BUNCH), .drv_cos(DRV0_COS), .drv_sin(DRV0_SIN));

	sbpt_top dut (.CLK(CLK), .RSTN(RSTN), .S_VALID(S_VALID), .S_SAMPLE(S_SAMPLE),
		.S_BUNCH(S_BUNCH), .S_READY(S_READY), .DRV0_COS(DRV0_COS), .DRV0_SIN(DRV0_SIN),
		.DRV0_FREQ(DRV0_FREQ), .SET_SEL_LSB(SET_SEL_LSB), .TRACK_FREQ(TRACK_FREQ),
		.DRV2_CORR(DRV2_CORR), .SB_BUNCH(SB_BUNCH), .BUS_ADDR(BUS_ADDR),
		.BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLK);
		BUS_WR <= 1'b1;
		BUS_ADDR <= a;
		BUS_WDATA <= v;
		@(posedge CLK);
		BUS_WR <= 1'b0;
	endtask

	// Read data is sampled in the single cycle that it stands
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge CLK);
		BUS_RD <= 1'b1;
		BUS_ADDR <= a;
		@(posedge CLK);
		BUS_RD <= 1'b0;
		#1 v = BUS_RDATA;
	endtask

	// Polls the update counter every second cycle, so intervals come out exact
	task automatic wait_upd(input int n);
		rd(sbpt_pkg::OFS_UPD, u0);
		k = 0;
		do begin
			rd(sbpt_pkg::OFS_UPD, d);
			k++;
		end while (d - u0 < 32'(n) && k < 3000);
		if (k >= 3000) begin
			err_count++;
			$display("[ERR] update count expected %h seen %h", u0 + 32'(n), d);
			report_and_stop();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
		logic [31:0] e[6] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h64};
		for (int i = 0; i < 6; i++) begin
			rd(a[i], d);
			check("reset value", d, e[i]);
		end
		@(posedge CLK);
		#1 check("read data after", BUS_RDATA, 32'h0);
		wr(8'h30, 32'hFFFF_FFFF);
		rd(8'h30, d);
		check("unmapped", d, 32'h0);
		wr(sbpt_pkg::OFS_RANGE, 32'hFFFF_FFFF);
		rd(sbpt_pkg::OFS_RANGE, d);
		check("range", d, 32'h7FFF_FFFF);
		wr(sbpt_pkg::OFS_BUNCH, 32'h2);
		@(posedge CLK);
		#1 check("shared bunch", {22'h0, SB_BUNCH}, 32'h2);
		wr(sbpt_pkg::OFS_GAIN, 32'h0000_FFFE);
		wr(sbpt_pkg::OFS_SETPT, 32'h100);
		wr(sbpt_pkg::OFS_RANGE, 32'h300);
		wr(sbpt_pkg::OFS_DECIM, 32'h10);
	endtask

	// 16 turns of 12288 give 3*2^16, which needs 13 shifts to pass half scale
	task automatic t_meas(input logic signed [15:0] c, input logic signed [15:0] s,
			input logic [15:0] ph);
		logic [31:0] p;
		cos_v <= c;
		sin_v <= s;
		// Third update is the first whose window holds only new drive values
		wait_upd(3);
		rd(sbpt_pkg::OFS_SHIFT, d);
		check("shift", d, 32'd13);
		wr(sbpt_pkg::OFS_SHIFT, 32'h1F);
		rd(sbpt_pkg::OFS_SHIFT, d);
		check("shift kept", d, 32'd13);
		rd(sbpt_pkg::OFS_MAG, d);
		check("magnitude", 32'(d > 78000 && d < 83000), 32'h1);
		rd(sbpt_pkg::OFS_PHASE, p);
		dif = p[15:0] - ph + 16'h0008;
		check("phase", 32'(dif <= 16'h0010), 32'h1);
		rd(sbpt_pkg::OFS_ERROR, d);
		check("error", d & 32'hFFFF, (32'h100 - p) & 32'hFFFF);
	endtask

	task automatic t_rate(input logic [31:0] dec);
		wr(sbpt_pkg::OFS_DECIM, dec);
		wait_upd(2);
		t0 = $time;
		wait_upd(1);
		check("update interval", 32'(($time - t0) / 20), dec * 8);
	endtask

	// Zero phase gives an error of exactly the setpoint, so the first step is gain times 0x100 and the second is clamped to the range
	task automatic t_loop();
		cos_v <= 16'sh4000;
		sin_v <= 16'sh0000;
		wait_upd(3);
		wr(sbpt_pkg::OFS_CTRL, 32'h3);
		wait_upd(1);
		check("track first", TRACK_FREQ, F - 32'd512);
		check("drive 2 first", DRV2_CORR, -32'd512);
		wait_upd(1);
		check("track clamped", TRACK_FREQ, F - 32'd768);
		check("drive 2 clamped", DRV2_CORR, -32'd768);
	endtask

	task automatic t_gate();
		wait_upd(1);
		wr(sbpt_pkg::OFS_CTRL, 32'h5);
		wait_upd(1);
		check("gated open", TRACK_FREQ, F);
		check("drive 2 open", DRV2_CORR, 32'h0);
		rd(sbpt_pkg::OFS_TRACK, d);
		check("track snapshot", d, F);
		SET_SEL_LSB <= 1'b1;
		wait_upd(1);
		check("gated closed", TRACK_FREQ, F - 32'd512);
		check("no follow", DRV2_CORR, 32'h0);
		wr(sbpt_pkg::OFS_CTRL, 32'h0);
		repeat (3) @(posedge CLK);
		#1 check("reopened", TRACK_FREQ, F);
	endtask

	// Every slot carries the tracked bunch, so the FIFO fills during processing
	task automatic t_fifo();
		wr(sbpt_pkg::OFS_DECIM, 32'h1);
		burst <= 1'b1;
		k = 0;
		do begin
			@(posedge CLK);
			#1 k++;
		end while (S_READY !== 1'b0 && k < 100);
		check("fifo full", {31'h0, S_READY}, 32'h0);
		burst <= 1'b0;
		wr(sbpt_pkg::OFS_BUNCH, 32'h3FF);
		k = 0;
		do begin
			@(posedge CLK);
			#1 k++;
		end while (S_READY !== 1'b1 && k < 500);
		check("fifo drained", {31'h0, S_READY}, 32'h1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(20 * 100000);
		err_count++;
		$display("[ERR] run time expected %s seen %s", "end", "hang");
		report_and_stop();
	end

	initial begin
		repeat (4) @(posedge CLK);
		#1 check("reset outputs", TRACK_FREQ | DRV2_CORR | BUS_RDATA, 32'h0);
		check("reset bunch", {22'h0, SB_BUNCH}, 32'h1);
		check("reset ready", {31'h0, S_READY}, 32'h0);
		repeat (4) @(posedge CLK);
		RSTN <= 1'b1;
		repeat (6) @(posedge CLK);
		t_regs();
		t_meas(16'sh4000, 16'sh0000, 16'h0000);
		t_meas(16'sh0000, 16'sh4000, 16'h4000);
		t_rate(32'h20);
		t_rate(32'h10);
		t_loop();
		t_gate();
		t_fifo();
		report_and_stop();
	end
endmodule

`default_nettype wire
